// [design/ordering_fifo.sv]
// Shared constants and the in-order urgent-stream FIFO.
`timescale 1ns/1ps
package ordering_pkg;
   localparam int ADDR_W       = 32;
   localparam int DATA_W       = 64;
   localparam int QUEUE_DEPTH  = 8;
   localparam int URGENT_DEPTH = 4;
   localparam int EPOCH_W      = 4;
   localparam int SNAP_W       = 8;
   localparam logic [DATA_W-1:0] FLUSH_FILL = 64'h0;

   typedef enum logic [1:0]
   {
      CMD_READ  = 2'h0,
      CMD_WRITE = 2'h1,
      CMD_FLUSH = 2'h2,
      CMD_FENCE = 2'h3
   } cmd_t;

   typedef enum logic [1:0]
   {
      SLOT_WAIT = 2'h0,
      SLOT_SENT = 2'h1,
      SLOT_DONE = 2'h3
   } slot_t;
endpackage : ordering_pkg

module ordering_fifo #(
   parameter int W     = 96,
   parameter int DEPTH = 4
) (
   input  wire logic         sys_clk, // Port clock.
   input  wire logic         rst,     // Synchronous reset, active high.
   input  wire logic         push,    // Store din this cycle.
   input  wire logic [W-1:0] din,     // Entry to store.
   input  wire logic         pop,     // Drop the head entry.
   output logic      [W-1:0] dout,    // Head entry.
   output logic              empty,   // No entry stored.
   output logic              full     // No room left.
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] store [DEPTH];
   logic [AW:0]  wptr;
   logic [AW:0]  rptr;

   // Pointers carry one extra bit so full and empty are told apart.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         wptr <= '0;
         rptr <= '0;
      end
      else
      begin
         if (push && !full)
            wptr <= wptr + 1'b1;
         if (pop && !empty)
            rptr <= rptr + 1'b1;
      end
   end

   // Entry storage is written only on an accepted push.
   always_ff @(posedge sys_clk)
   begin
      if (push && !full)
         store[wptr[AW-1:0]] <= din;
   end

   // Status and head word.
   assign empty = (wptr == rptr);
   assign full  = (wptr[AW] != rptr[AW]) &&
                  (wptr[AW-1:0] == rptr[AW-1:0]);
   assign dout  = store[rptr[AW-1:0]];
endmodule : ordering_fifo

// [design/request_ordering_fence_flush.sv]
// Request ordering core: two priority streams, flush and fence.
//
// Overview of operation
// R1: Master never stalls data on other transactions.
// R2: Flush and fence never disturb urgent requests.
// R3: Flush waits until earlier writes are visible.
// R4: Flush completes with one arbitrary quadword reply.
// R5: Flush holds one queue slot until replied.
// R6: Queue may be entirely filled with flushes.
// R7: Pre-fence normal requests finish before post-fence.
// R8: Post-fence writes never pass pre-fence reads.
// R9: Post-fence reads never pass pre-fence reads.
// R10: Urgent requests ignore fence boundaries.
// R11: Fence takes no queue slot, unlimited count.
// R12: Fence order holds at memory, not bus.
// R13: Urgent requests win memory over normal ones.
// R14: Urgent requests bypass normal stream freely.
// R15: Urgent read replies return in request order.
// R16: Urgent writes complete in request order.
// R17: No order between urgent reads and writes.
// R18: Every reply carries its stream identity.
// R19: Urgent write data accepted without delay. The code holds req_ready low while the urgent write FIFO is full.
// R20: Master uses urgent commands sparingly.
// R21: Normal read replies return in request order.
// R22: Normal writes applied in request order.
// R23: Normal reads see earlier normal writes.
// R24: Writes may pass reads outside fences.
// R25: Fence epoch gates issue until older done.
`timescale 1ns/1ps
module request_ordering_fence_flush
   import ordering_pkg::*;
#(
   parameter int DEPTH   = QUEUE_DEPTH,
   parameter int U_DEPTH = URGENT_DEPTH,
   parameter int IDX_W   = $clog2(QUEUE_DEPTH)
) (
   input  wire logic              sys_clk,    // Port clock, 250 MHz.
   input  wire logic              rst,        // Synchronous reset, high.
   input  wire logic              req_valid,  // Master offers a request.
   input  wire cmd_t              req_cmd,    // Read, write, flush, fence.
   input  wire logic              req_urgent, // Urgent stream request.
   input  wire logic [ADDR_W-1:0] req_addr,   // Request address.
   input  wire logic [DATA_W-1:0] req_data,   // Write data.
   output logic                   req_ready,  // Request taken this cycle.
   output logic                   rsp_valid,  // Reply pulse.
   output logic                   rsp_urgent, // Reply is urgent stream.
   output logic      [DATA_W-1:0] rsp_data,   // Reply data.
   output logic                   mem_valid,  // Memory request offered.
   output logic                   mem_write,  // Memory request is a write.
   output logic      [ADDR_W-1:0] mem_addr,   // Memory address.
   output logic      [DATA_W-1:0] mem_data,   // Memory write data.
   output logic        [IDX_W:0]  mem_id,     // Tag, top bit urgent.
   input  wire logic              mem_ready,  // Memory takes request.
   input  wire logic              cpl_valid,  // Memory completion pulse.
   input  wire logic   [IDX_W:0]  cpl_id,     // Tag of the completion.
   input  wire logic [DATA_W-1:0] cpl_data    // Read data of completion.
);
   localparam int UW = ADDR_W + DATA_W;
   localparam logic [IDX_W:0] DEPTH_CNT = (IDX_W+1)'(DEPTH);

   // Normal stream slot storage.
   cmd_t               slot_cmd   [DEPTH];
   logic [ADDR_W-1:0]  slot_addr  [DEPTH];
   logic [DATA_W-1:0]  slot_data  [DEPTH];
   logic [EPOCH_W-1:0] slot_epoch [DEPTH];
   logic [SNAP_W-1:0]  slot_snap  [DEPTH];
   slot_t              slot_state [DEPTH];
   logic [DATA_W-1:0]  slot_rdata [DEPTH];

   logic [IDX_W:0]     alloc_ptr;
   logic [IDX_W:0]     issue_ptr;
   logic [IDX_W:0]     ret_ptr;
   logic [IDX_W:0]     inflight;
   logic [EPOCH_W-1:0] cur_epoch;
   logic [EPOCH_W-1:0] last_epoch;
   logic               fence_pend;
   logic [SNAP_W-1:0]  uw_acc;
   logic [SNAP_W-1:0]  uw_done;
   logic               u_busy;
   logic               u_is_write;

   logic               is_rw;
   logic               q_full;
   logic               take_norm;
   logic               take_uw;
   logic               take_ur;
   logic               take_fence;
   logic [UW-1:0]      uw_head;
   logic [UW-1:0]      ur_head;
   logic               uw_empty;
   logic               uw_full;
   logic               ur_empty;
   logic               ur_full;
   logic               u_pick_w;
   logic               u_pick_r;
   logic               u_go;
   logic [IDX_W-1:0]   head;
   logic               head_valid;
   logic               epoch_ok;
   logic               snap_ok;
   logic [SNAP_W-1:0]  snap_diff;
   logic               flush_go;
   logic               norm_want;
   logic               norm_go;
   logic [IDX_W-1:0]   rhead;
   logic               retire;
   logic               cpl_urgent;
   logic               u_read_rsp;

   // Request steering; a fence is always taken and uses no slot.
   assign is_rw      = (req_cmd == CMD_READ) || (req_cmd == CMD_WRITE);
   assign q_full     = ((alloc_ptr - ret_ptr) == DEPTH_CNT); // R6
   assign take_fence = req_valid && (req_cmd == CMD_FENCE); // R11
   assign take_uw    = req_valid && req_urgent && (req_cmd == CMD_WRITE)
                       && !uw_full; // R19
   assign take_ur    = req_valid && req_urgent && (req_cmd == CMD_READ)
                       && !ur_full;
   assign take_norm  = req_valid && !(req_urgent && is_rw)
                       && (req_cmd != CMD_FENCE) && !q_full; // R2 R5

   // Handshake back to the master.
   always_comb
   begin
      if (req_cmd == CMD_FENCE)
         req_ready = 1'b1;
      else if (req_urgent && req_cmd == CMD_WRITE)
         req_ready = !uw_full;
      else if (req_urgent && req_cmd == CMD_READ)
         req_ready = !ur_full;
      else
         req_ready = !q_full;
   end

   // Urgent writes and reads each keep their own strict order.
   ordering_fifo #(.W(UW), .DEPTH(U_DEPTH)) urgent_writes (
      .sys_clk (sys_clk),
      .rst     (rst),
      .push    (take_uw),
      .din     ({req_addr, req_data}),
      .pop     (u_go && u_pick_w),
      .dout    (uw_head),
      .empty   (uw_empty),
      .full    (uw_full)
   ); // R16

   ordering_fifo #(.W(UW), .DEPTH(U_DEPTH)) urgent_reads (
      .sys_clk (sys_clk),
      .rst     (rst),
      .push    (take_ur),
      .din     ({req_addr, req_data}),
      .pop     (u_go && u_pick_r),
      .dout    (ur_head),
      .empty   (ur_empty),
      .full    (ur_full)
   ); // R15

   // One urgent access in flight at a time, writes picked first.
   assign u_pick_w = !u_busy && !uw_empty; // R17
   assign u_pick_r = !u_busy && uw_empty && !ur_empty;
   assign u_go     = (u_pick_w || u_pick_r) && mem_ready;

   // Normal head issue, gated by the fence epoch of what is in flight.
   assign head       = issue_ptr[IDX_W-1:0];
   assign head_valid = (issue_ptr != alloc_ptr);
   assign epoch_ok   = (slot_epoch[head] == last_epoch)
                       || (inflight == '0); // R25 R7 R8 R9 R12
   assign snap_diff  = slot_snap[head] - uw_done;
   assign snap_ok    = (snap_diff == '0) || snap_diff[SNAP_W-1];
   assign flush_go   = head_valid && (slot_cmd[head] == CMD_FLUSH)
                       && (inflight == '0) && snap_ok; // R3
   assign norm_want  = head_valid && (slot_cmd[head] != CMD_FLUSH)
                       && epoch_ok; // R22 R23 R24
   assign norm_go    = norm_want && !(u_pick_w || u_pick_r)
                       && mem_ready; // R13 R14 R10

   // Memory request mux; urgent requests take the port first.
   always_comb
   begin
      if (u_pick_w || u_pick_r)
      begin
         mem_valid = 1'b1;
         mem_write = u_pick_w;
         mem_addr  = u_pick_w ? uw_head[UW-1:DATA_W] : ur_head[UW-1:DATA_W];
         mem_data  = u_pick_w ? uw_head[DATA_W-1:0] : ur_head[DATA_W-1:0];
         mem_id    = {1'b1, {IDX_W{1'b0}}};
      end
      else
      begin
         mem_valid = norm_want;
         mem_write = (slot_cmd[head] == CMD_WRITE);
         mem_addr  = slot_addr[head];
         mem_data  = slot_data[head];
         mem_id    = {1'b0, head};
      end
   end

   // Completion decode and in-order retirement of the normal queue.
   assign cpl_urgent = cpl_valid && cpl_id[IDX_W];
   assign u_read_rsp = cpl_urgent && !u_is_write;
   assign rhead      = ret_ptr[IDX_W-1:0];
   assign retire     = (ret_ptr != issue_ptr)
                       && (slot_state[rhead] == SLOT_DONE)
                       && !u_read_rsp; // R21

   // Slot contents and their progress through the queue.
   always_ff @(posedge sys_clk)
   begin
      if (take_norm)
      begin
         slot_cmd[alloc_ptr[IDX_W-1:0]]   <= req_cmd;
         slot_addr[alloc_ptr[IDX_W-1:0]]  <= req_addr;
         slot_data[alloc_ptr[IDX_W-1:0]]  <= req_data;
         slot_epoch[alloc_ptr[IDX_W-1:0]] <= cur_epoch;
         slot_snap[alloc_ptr[IDX_W-1:0]]  <= uw_acc;
         slot_state[alloc_ptr[IDX_W-1:0]] <= SLOT_WAIT;
      end
      if (norm_go)
         slot_state[head] <= SLOT_SENT;
      if (flush_go)
         slot_state[head] <= SLOT_DONE; // R4
      if (cpl_valid && !cpl_id[IDX_W])
      begin
         slot_state[cpl_id[IDX_W-1:0]] <= SLOT_DONE;
         slot_rdata[cpl_id[IDX_W-1:0]] <= cpl_data;
      end
   end

   // Queue pointers; a slot frees only when its reply has gone out.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         alloc_ptr <= '0;
         issue_ptr <= '0;
         ret_ptr   <= '0;
      end
      else
      begin
         if (take_norm)
            alloc_ptr <= alloc_ptr + 1'b1;
         if (norm_go || flush_go)
            issue_ptr <= issue_ptr + 1'b1;
         if (retire)
            ret_ptr <= ret_ptr + 1'b1; // R5
      end
   end

   // Count of normal accesses sent to memory and not yet completed.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         inflight <= '0;
      else if (norm_go && !(cpl_valid && !cpl_id[IDX_W]))
         inflight <= inflight + 1'b1;
      else if (!norm_go && cpl_valid && !cpl_id[IDX_W])
         inflight <= inflight - 1'b1;
   end

   // Marks a fence seen since the last normal entry. Repeated fences share
   // one epoch, so the epoch tag cannot wrap onto an entry still in flight.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         fence_pend <= 1'b0;
      else if (take_fence)
         fence_pend <= 1'b1; // R11
      else if (take_norm)
         fence_pend <= 1'b0;
   end

   // Fence epochs: current tag for new entries, last one sent out.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         cur_epoch  <= '0;
         last_epoch <= '0;
      end
      else
      begin
         if (take_fence && !fence_pend)
            cur_epoch <= cur_epoch + 1'b1; // R25
         if (norm_go || flush_go)
            last_epoch <= slot_epoch[head];
      end
   end

   // Urgent write accept and completion counts, seen by flushes.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         uw_acc  <= '0;
         uw_done <= '0;
      end
      else
      begin
         if (take_uw)
            uw_acc <= uw_acc + 1'b1;
         if (cpl_urgent && u_is_write)
            uw_done <= uw_done + 1'b1; // R3
      end
   end

   // Single urgent access tracker.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         u_busy     <= 1'b0;
         u_is_write <= 1'b0;
      end
      else if (u_go)
      begin
         u_busy     <= 1'b1;
         u_is_write <= u_pick_w;
      end
      else if (cpl_urgent)
         u_busy <= 1'b0;
   end

   // Reply port; urgent read data is sent ahead of normal replies.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         rsp_valid  <= 1'b0;
         rsp_urgent <= 1'b0;
         rsp_data   <= '0;
      end
      else if (u_read_rsp)
      begin
         rsp_valid  <= 1'b1;
         rsp_urgent <= 1'b1; // R18
         rsp_data   <= cpl_data;
      end
      else if (retire && slot_cmd[rhead] != CMD_WRITE)
      begin
         rsp_valid  <= 1'b1;
         rsp_urgent <= 1'b0; // R18
         rsp_data   <= (slot_cmd[rhead] == CMD_FLUSH) ?
                       FLUSH_FILL : slot_rdata[rhead]; // R4
      end
      else
         rsp_valid <= 1'b0;
   end
endmodule : request_ordering_fence_flush

// [tb/ordering_props.sv]
// Concurrent checks on the request ordering core's ports.
`timescale 1ns/1ps
module ordering_props
   import ordering_pkg::*;
#(
   parameter int DEPTH = QUEUE_DEPTH,
   parameter int IDX_W = $clog2(QUEUE_DEPTH)
) (
   input wire logic              sys_clk,    // Clock.
   input wire logic              rst,        // Reset.
   input wire logic              req_valid,  // Request offered.
   input wire cmd_t              req_cmd,    // Command.
   input wire logic              req_urgent, // Urgent stream.
   input wire logic [ADDR_W-1:0] req_addr,   // Address.
   input wire logic [DATA_W-1:0] req_data,   // Write data.
   input wire logic              req_ready,  // Request taken.
   input wire logic              rsp_valid,  // Reply pulse.
   input wire logic              rsp_urgent, // Reply stream.
   input wire logic [DATA_W-1:0] rsp_data,   // Reply data.
   input wire logic              mem_valid,  // Memory request.
   input wire logic              mem_write,  // Memory write.
   input wire logic [ADDR_W-1:0] mem_addr,   // Memory address.
   input wire logic [DATA_W-1:0] mem_data,   // Memory data.
   input wire logic [IDX_W:0]    mem_id,     // Memory tag.
   input wire logic              mem_ready,  // Memory takes it.
   input wire logic              cpl_valid,  // Completion.
   input wire logic [IDX_W:0]    cpl_id,     // Completion tag.
   input wire logic [DATA_W-1:0] cpl_data    // Completion data.
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   logic       u_write;
   logic [1:0] u_open;
   logic [4:0] n_open;
   logic       kinds [0:15];
   logic [3:0] wr_ptr;
   logic [3:0] rd_ptr;
   logic       u_take;
   logic       u_cpl;
   logic       u_rd_cpl;
   logic       n_take;
   logic       n_cpl;
   logic       q_take;

   // Classify memory traffic and normal replies by stream.
   assign u_take   = mem_valid && mem_ready && mem_id[IDX_W];
   assign n_take   = mem_valid && mem_ready && !mem_id[IDX_W];
   assign u_cpl    = cpl_valid && cpl_id[IDX_W];
   assign n_cpl    = cpl_valid && !cpl_id[IDX_W];
   assign u_rd_cpl = u_cpl && !u_write;
   assign q_take   = req_valid && req_ready && (req_cmd == CMD_FLUSH
                     || (req_cmd == CMD_READ && !req_urgent));

   // Counts accesses in flight and tracks the kind of each normal reply.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         u_write <= 1'b0;
         u_open  <= 2'h0;
         n_open  <= 5'h0;
         wr_ptr  <= 4'h0;
         rd_ptr  <= 4'h0;
      end
      else
      begin
         if (u_take)
            u_write <= mem_write;
         u_open <= u_open + 2'(u_take) - 2'(u_cpl);
         n_open <= n_open + 5'(n_take) - 5'(n_cpl);
         wr_ptr <= wr_ptr + 4'(q_take);
         rd_ptr <= rd_ptr + 4'(rsp_valid && !rsp_urgent);
      end
   end

   // Remembers whether each queued normal reply belongs to a flush.
   always_ff @(posedge sys_clk)
   begin
      if (q_take)
         kinds[wr_ptr] <= (req_cmd == CMD_FLUSH);
   end

   reset_quiet_a: assert property (disable iff (1'b0)
      rst |=> !rsp_valid && !mem_valid) else $error("busy after reset");
   fence_taken_a: assert property (req_valid && req_cmd == CMD_FENCE
      |-> req_ready) else $error("fence refused");
   mem_hold_a: assert property (mem_valid && !mem_ready
      |=> mem_valid) else $error("memory request dropped");
   urgent_single_a: assert property (mem_valid && mem_id[IDX_W]
      |-> u_open == 2'h0 || (u_open == 2'h1 && u_cpl))
      else $error("second urgent access in flight");
   urgent_tag_a: assert property (mem_valid && mem_id[IDX_W]
      |-> mem_id[IDX_W-1:0] == '0) else $error("urgent tag low bits set");
   urgent_reply_a: assert property (u_rd_cpl |=> rsp_valid
      && rsp_urgent && rsp_data == $past(cpl_data))
      else $error("urgent read reply missing");
   urgent_cause_a: assert property (rsp_valid && rsp_urgent
      |-> $past(u_rd_cpl)) else $error("urgent reply without completion");
   flush_fill_a: assert property (rsp_valid && !rsp_urgent
      && kinds[rd_ptr] |-> rsp_data == FLUSH_FILL)
      else $error("flush reply data wrong");
   normal_bound_a: assert property (n_open <= 5'(DEPTH))
      else $error("too many normal accesses in flight");
endmodule : ordering_props

bind request_ordering_fence_flush ordering_props #(
   .DEPTH (DEPTH),
   .IDX_W (IDX_W)
) u_props (
   .sys_clk    (sys_clk),
   .rst        (rst),
   .req_valid  (req_valid),
   .req_cmd    (req_cmd),
   .req_urgent (req_urgent),
   .req_addr   (req_addr),
   .req_data   (req_data),
   .req_ready  (req_ready),
   .rsp_valid  (rsp_valid),
   .rsp_urgent (rsp_urgent),
   .rsp_data   (rsp_data),
   .mem_valid  (mem_valid),
   .mem_write  (mem_write),
   .mem_addr   (mem_addr),
   .mem_data   (mem_data),
   .mem_id     (mem_id),
   .mem_ready  (mem_ready),
   .cpl_valid  (cpl_valid),
   .cpl_id     (cpl_id),
   .cpl_data   (cpl_data)
);

// [tb/mem_partner.sv]
// Memory partner: stalls on demand and completes newest request first.
`timescale 1ns/1ps
module mem_partner
   import ordering_pkg::*;
(
   input  wire logic              sys_clk,   // Clock.
   input  wire logic              rst,       // Reset.
   input  wire logic              hold,      // Refuse all requests.
   input  wire logic              slow,      // Stall and answer late.
   input  wire logic              mem_valid, // Request offered.
   input  wire logic              mem_write, // Request is a write.
   input  wire logic [ADDR_W-1:0] mem_addr,  // Address.
   input  wire logic [DATA_W-1:0] mem_data,  // Write data.
   input  wire logic [3:0]        mem_id,    // Tag.
   output logic                   mem_ready, // Request taken.
   output logic                   cpl_valid, // Completion pulse.
   output logic      [3:0]        cpl_id,    // Completion tag.
   output logic      [DATA_W-1:0] cpl_data   // Read data.
);
   logic [DATA_W-1:0] store [0:255];
   logic [3:0]        tags [$];
   logic [7:0]        addrs [$];
   int                gap;

   // Writes land on acceptance and reads sample at completion; in slow mode
   // each acceptance restarts the delay, so a write let past an older read
   // would show up in that read's data.
   always @(posedge sys_clk)
   begin
      cpl_valid <= 1'b0;
      cpl_data  <= ~cpl_data;
      if (rst)
      begin
         mem_ready <= 1'b0;
         cpl_data  <= '0;
         cpl_id    <= 4'h0;
         tags.delete();
         addrs.delete();
         gap = 0;
      end
      else
      begin
         mem_ready <= hold ? 1'b0 : (slow ? ~mem_ready : 1'b1);
         if (mem_valid && mem_ready)
         begin
            if (mem_write)
               store[mem_addr[7:0]] = mem_data;
            tags.push_back(mem_id);
            addrs.push_back(mem_addr[7:0]);
            if (slow)
               gap = 4;
         end
         if (gap > 0)
            gap--;
         else if (tags.size() > 0 && !hold)
         begin
            cpl_valid <= 1'b1;
            cpl_id    <= tags.pop_back();
            cpl_data  <= store[addrs.pop_back()];
            gap = slow ? 4 : 0;
         end
      end
   end
endmodule : mem_partner

// [tb/tb_request_ordering_fence_flush.sv]
// Self-checking bench for the request ordering core.
`timescale 1ns/1ps
module tb_request_ordering_fence_flush;
   import ordering_pkg::*;
   logic              sys_clk, rst, req_valid, req_urgent, req_ready;
   logic              rsp_valid, rsp_urgent, mem_valid, mem_write;
   logic              mem_ready, cpl_valid, hold, slow;
   cmd_t              req_cmd;
   logic [ADDR_W-1:0] req_addr, mem_addr;
   logic [DATA_W-1:0] req_data, rsp_data, mem_data, cpl_data;
   logic [3:0]        mem_id, cpl_id;
   logic [DATA_W:0]   rsps [$];
   int                err_count, total_checks;

   request_ordering_fence_flush u_dut (.sys_clk(sys_clk), .rst(rst),
      .req_valid(req_valid), .req_cmd(req_cmd), .req_urgent(req_urgent),
      .req_addr(req_addr), .req_data(req_data), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_urgent(rsp_urgent), .rsp_data(rsp_data),
      .mem_valid(mem_valid), .mem_write(mem_write), .mem_addr(mem_addr),
      .mem_data(mem_data), .mem_id(mem_id), .mem_ready(mem_ready),
      .cpl_valid(cpl_valid), .cpl_id(cpl_id), .cpl_data(cpl_data));
   mem_partner u_mem (.sys_clk(sys_clk), .rst(rst), .hold(hold),
      .slow(slow), .mem_valid(mem_valid), .mem_write(mem_write),
      .mem_addr(mem_addr), .mem_data(mem_data), .mem_id(mem_id),
      .mem_ready(mem_ready), .cpl_valid(cpl_valid), .cpl_id(cpl_id),
      .cpl_data(cpl_data));

   // Free-running 250 MHz clock.
   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   // Collects every reply with its stream flag.
   always @(posedge sys_clk)
      if (rsp_valid === 1'b1)
         rsps.push_back({rsp_urgent, rsp_data});

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up

   task automatic check(input logic [DATA_W:0] got,
                        input logic [DATA_W:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // Holds the request until the core takes it; the master never stalls.
   task automatic send(input cmd_t c, input logic u, input logic [7:0] a,
                       input logic [DATA_W-1:0] d);
      int n;
      req_valid  <= 1'b1;
      req_cmd    <= c;
      req_urgent <= u;
      req_addr   <= {24'h0, a};
      req_data   <= d;
      for (n = 0; n < 300; n++)
      begin
         @(negedge sys_clk);
         if (req_ready === 1'b1)
            break;
      end
      if (n == 300)
      begin
         err_count++;
         wrap_up();
      end
      @(posedge sys_clk);
   endtask : send

   task automatic expect_rsp(input logic u, input logic [DATA_W-1:0] d);
      int n;
      for (n = 0; n < 500 && rsps.size() == 0; n++)
         @(posedge sys_clk);
      if (rsps.size() == 0)
      begin
         err_count++;
         wrap_up();
      end
      check(rsps.pop_front(), {u, d});
   endtask : expect_rsp

   // Overlapping writes then reads under a reordering, stalling memory.
   task automatic t_normal();
      slow <= 1'b1;
      send(CMD_WRITE, 1'b0, 8'h01, 64'h11);
      send(CMD_WRITE, 1'b0, 8'h01, 64'h22);
      send(CMD_WRITE, 1'b0, 8'h02, 64'h33);
      send(CMD_READ, 1'b0, 8'h01, 64'h0);
      send(CMD_READ, 1'b0, 8'h02, 64'h0);
      req_valid <= 1'b0;
      expect_rsp(1'b0, 64'h22);
      expect_rsp(1'b0, 64'h33);
      slow <= 1'b0;
   endtask : t_normal

   // Sparse urgent traffic; replies carry the urgent flag in order.
   task automatic t_urgent();
      send(CMD_WRITE, 1'b1, 8'h03, 64'h44);
      send(CMD_READ, 1'b1, 8'h03, 64'h0);
      send(CMD_READ, 1'b1, 8'h01, 64'h0);
      req_valid <= 1'b0;
      expect_rsp(1'b1, 64'h44);
      expect_rsp(1'b1, 64'h22);
   endtask : t_urgent

   // Fills the queue with a write, a read and flushes, then a fence.
   task automatic t_flush();
      int i;
      hold <= 1'b1;
      send(CMD_WRITE, 1'b0, 8'h04, 64'h55);
      send(CMD_READ, 1'b0, 8'h02, 64'h0);
      for (i = 0; i < 6; i++)
         send(CMD_FLUSH, 1'b0, 8'h00, 64'h0);
      send(CMD_FENCE, 1'b0, 8'h00, 64'h0);
      req_valid <= 1'b0;
      req_cmd   <= CMD_FLUSH;
      @(negedge sys_clk);
      check({64'h0, req_ready}, 65'h0);
      @(posedge sys_clk);
      hold <= 1'b0;
      expect_rsp(1'b0, 64'h33);
      for (i = 0; i < 6; i++)
         expect_rsp(1'b0, FLUSH_FILL);
      check({1'b0, u_mem.store[4]}, 65'h55);
   endtask : t_flush

   // A write after a fence must not reach memory before the older read.
   task automatic t_fence();
      slow <= 1'b1;
      send(CMD_READ, 1'b0, 8'h01, 64'h0);
      send(CMD_FENCE, 1'b0, 8'h00, 64'h0);
      send(CMD_WRITE, 1'b0, 8'h01, 64'h66);
      send(CMD_READ, 1'b0, 8'h01, 64'h0);
      req_valid <= 1'b0;
      expect_rsp(1'b0, 64'h22);
      expect_rsp(1'b0, 64'h66);
   endtask : t_fence

   // Reset for ten cycles, then the scenarios in turn.
   initial
   begin
      err_count    = 0;
      total_checks = 0;
      rst          = 1'b1;
      req_valid    = 1'b0;
      req_cmd      = CMD_READ;
      req_urgent   = 1'b0;
      req_addr     = '0;
      req_data     = '0;
      hold         = 1'b0;
      slow         = 1'b0;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      t_normal();
      t_urgent();
      t_flush();
      t_fence();
      wrap_up();
   end
endmodule : tb_request_ordering_fence_flush
